// *** hdl/fcsif_top.sv ***
// top: status register, event flags with set/clear/enable, interrupt, AXI4-Lite slave
// What this block does
// R1: status top nibble counts power-up checkerboard check failures since reset.
// R2: status bits 27:24 show write buffer valid words, reset zero.
// R3: flag bit 8 sets on write command in low-voltage mode.
// R4: flag bit 6 sets on write data buffer overflow.
// R5: flag bit 5 sets on cache RAM parity error.
// R6: flag bit 4 sets when power-up finished after power-up command.
// R7: flag bit 3 sets when miss counter overflows.
// R8: flag bit 2 sets when hit counter overflows.
// R9: flag bit 1 sets when a flash write completes.
// R10: flag bit 0 sets on erase done; flags reset zero; 7, 31:9 reserved.
// R11: writing one to set register raises matching flag; zero does nothing.
// R12: writing one to clear register clears flag; optional read-clear returns flags.
// R13: software writes write data only while write data ready is set.
// R14: enable register holds erase-done enable at bit 0, same layout as flags.
// R15: interrupt is high while any enabled flag is set.
// R16: hardware set wins over simultaneous software clear.
//
// Added by the designer: the AXI4-Lite register port.
module fcsif_top
  import fcsif_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // axi4-lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // controller side
  input  wire fcsif_events_t    events,
  input  wire fcsif_status_in_t status_in,
  // interrupt
  output logic                  irq
);
  typedef struct packed {
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [8:0]       enable;
    logic             read_clear_en;
    logic [3:0]       fail_count;
    logic [3:0]       wbuf_valid;
    logic [6:0]       status_lo;
  } fcsif_state_t;

  fcsif_state_t state_reg;
  fcsif_state_t state_next;

  logic [8:0] flags;
  logic [8:0] hw_set;
  logic [8:0] sw_set;
  logic [8:0] sw_clr;
  logic       do_write;
  logic       do_read;
  logic [7:0] waddr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] status_word;

  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;

  // a write completes once both halves are present, held or arriving now
  always_comb begin
    waddr    = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
    wval     = state_reg.w_held ? state_reg.w_data : s_axi_wdata;
    wmask    = {{8{state_reg.w_held ? state_reg.w_strb[3] : s_axi_wstrb[3]}},
                {8{state_reg.w_held ? state_reg.w_strb[2] : s_axi_wstrb[2]}},
                {8{state_reg.w_held ? state_reg.w_strb[1] : s_axi_wstrb[1]}},
                {8{state_reg.w_held ? state_reg.w_strb[0] : s_axi_wstrb[0]}}};
    do_write = !state_reg.bvalid
               && (state_reg.aw_held || s_axi_awvalid)
               && (state_reg.w_held || s_axi_wvalid);
    do_read  = s_axi_arvalid && !state_reg.rvalid;
  end

  always_comb begin
    hw_set = '0;
    // R3: low-voltage write
    hw_set[FCSIF_BIT_LV_WRITE]   = events.lv_write;
    // R4: buffer overflow
    hw_set[FCSIF_BIT_WBUF_OVF]   = events.wbuf_ovf;
    // R5: cache parity
    hw_set[FCSIF_BIT_CACHE_PAR]  = events.cache_par;
    // R6: power-up done
    hw_set[FCSIF_BIT_PWRUP_DONE] = events.pwrup_done;
    // R7: miss overflow
    hw_set[FCSIF_BIT_MISS_OVF]   = events.miss_ovf;
    // R8: hit overflow
    hw_set[FCSIF_BIT_HIT_OVF]    = events.hit_ovf;
    // R9: write done
    hw_set[FCSIF_BIT_WRITE_DONE] = events.write_done;
    // R10: erase done
    hw_set[FCSIF_BIT_ERASE_DONE] = events.erase_done;
  end

  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    // R11: write one to set
    if (do_write && waddr == FCSIF_OFS_FLAGS_SET) begin
      sw_set = wval[8:0] & wmask[8:0] & FCSIF_FLAG_MASK;
    end
    // R12: write one to clear
    if (do_write && waddr == FCSIF_OFS_FLAGS_CLR) begin
      sw_clr = wval[8:0] & wmask[8:0] & FCSIF_FLAG_MASK;
    end
    // R12: read-clear option clears what it returns
    if (do_read && state_reg.read_clear_en && s_axi_araddr == FCSIF_OFS_FLAGS_CLR) begin
      sw_clr = sw_clr | flags;
    end
  end

  // R16: each flag lets its set win over a clear
  genvar gi;
  generate
    for (gi = 0; gi < FCSIF_NFLAGS; gi++) begin : g_flag
      if (FCSIF_FLAG_MASK[gi]) begin : g_used
        fcsif_flag_bit u_flag (
          .aclk    (aclk),
          .aresetn (aresetn),
          .hw_set  (hw_set[gi]),
          .sw_set  (sw_set[gi]),
          .sw_clr  (sw_clr[gi]),
          .flag    (flags[gi])
        );
      end else begin : g_rsvd
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    status_word = '0;
    // R1: failure count
    status_word[FCSIF_FAILCNT_LSB +: 4] = state_reg.fail_count;
    // R2: write buffer valid words
    status_word[FCSIF_WBVALID_LSB +: 4] = state_reg.wbuf_valid;
    status_word[6:0]                    = state_reg.status_lo;
  end

  always_comb begin
    state_next = state_reg;
    // R1: count saturates rather than wrap to zero
    if (status_in.pattern_fail && state_reg.fail_count != 4'hF) begin
      state_next.fail_count = state_reg.fail_count + 4'h1;
    end
    state_next.wbuf_valid = status_in.write_buffer_valid;
    // R13: ready bit shown so software can pace its data writes
    state_next.status_lo  = {status_in.perf_counters_running, status_in.erase_was_aborted,
                             status_in.word_write_timeout, status_in.write_data_ready,
                             status_in.invalid_target_address, status_in.access_locked,
                             status_in.busy};

    if (s_axi_awvalid && s_axi_awready && !do_write) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !do_write) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = FCSIF_RESP_OKAY;
      case (waddr)
        // R14: enable shares the flag layout
        FCSIF_OFS_ENABLE: begin
          state_next.enable = ((state_reg.enable & ~wmask[8:0]) | (wval[8:0] & wmask[8:0]))
                              & FCSIF_FLAG_MASK;
        end
        FCSIF_OFS_OPTIONS: begin
          if (wmask[0]) begin
            state_next.read_clear_en = wval[0];
          end
        end
        FCSIF_OFS_FLAGS_SET, FCSIF_OFS_FLAGS_CLR, FCSIF_OFS_FLAGS, FCSIF_OFS_STATUS: begin
          state_next.bresp = FCSIF_RESP_OKAY;
        end
        default: begin
          state_next.bresp = FCSIF_RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    if (do_read) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = FCSIF_RESP_OKAY;
      case (s_axi_araddr)
        FCSIF_OFS_STATUS:    state_next.rdata = status_word;
        FCSIF_OFS_FLAGS:     state_next.rdata = {23'h0, flags};
        FCSIF_OFS_ENABLE:    state_next.rdata = {23'h0, state_reg.enable};
        FCSIF_OFS_OPTIONS:   state_next.rdata = {31'h0, state_reg.read_clear_en};
        // write-only set register reads zero
        FCSIF_OFS_FLAGS_SET: state_next.rdata = 32'h0;
        FCSIF_OFS_FLAGS_CLR: begin
          state_next.rdata = state_reg.read_clear_en ? {23'h0, flags} : 32'h0;
        end
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = FCSIF_RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg               <= '0;
      state_reg.fail_count    <= FCSIF_FAILCNT_RESET;
      state_reg.wbuf_valid    <= FCSIF_WBVALID_RESET;
      state_reg.enable        <= FCSIF_FLAGS_RESET;
      state_reg.status_lo     <= FCSIF_STATUS_LO_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp  = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp  = state_reg.rresp;
  assign s_axi_rdata  = state_reg.rdata;

  // R15: masked flag OR
  assign irq = |(flags & state_reg.enable);
endmodule : fcsif_top

// *** hdl/fcsif_pkg.sv ***
// package: register map, field layout and carrier types of the flash status and event flag block
package fcsif_pkg;
  localparam logic [7:0] FCSIF_OFS_STATUS     = 8'h1C;
  localparam logic [7:0] FCSIF_OFS_FLAGS      = 8'h30;
  localparam logic [7:0] FCSIF_OFS_FLAGS_SET  = 8'h34;
  localparam logic [7:0] FCSIF_OFS_FLAGS_CLR  = 8'h38;
  localparam logic [7:0] FCSIF_OFS_ENABLE     = 8'h3C;
  localparam logic [7:0] FCSIF_OFS_OPTIONS    = 8'h40;

  localparam int FCSIF_FAILCNT_LSB = 28;
  localparam int FCSIF_WBVALID_LSB = 24;
  localparam int FCSIF_NFLAGS      = 9;
  localparam logic [8:0] FCSIF_FLAG_MASK = 9'h17F;

  localparam int FCSIF_BIT_ERASE_DONE = 0;
  localparam int FCSIF_BIT_WRITE_DONE = 1;
  localparam int FCSIF_BIT_HIT_OVF    = 2;
  localparam int FCSIF_BIT_MISS_OVF   = 3;
  localparam int FCSIF_BIT_PWRUP_DONE = 4;
  localparam int FCSIF_BIT_CACHE_PAR  = 5;
  localparam int FCSIF_BIT_WBUF_OVF   = 6;
  localparam int FCSIF_BIT_LV_WRITE   = 8;

  localparam logic [3:0] FCSIF_FAILCNT_RESET = 4'h0;
  localparam logic [3:0] FCSIF_WBVALID_RESET = 4'h0;
  localparam logic [8:0] FCSIF_FLAGS_RESET   = 9'h000;
  localparam logic [6:0] FCSIF_STATUS_LO_RESET = 7'h08;
  localparam logic [1:0] FCSIF_RESP_OKAY     = 2'h0;
  localparam logic [1:0] FCSIF_RESP_SLVERR   = 2'h2;

  // hardware events, one-cycle pulses
  typedef struct packed {
    logic lv_write;
    logic wbuf_ovf;
    logic cache_par;
    logic pwrup_done;
    logic miss_ovf;
    logic hit_ovf;
    logic write_done;
    logic erase_done;
  } fcsif_events_t;

  // status levels owned by the controller around this block
  typedef struct packed {
    logic       perf_counters_running;
    logic       erase_was_aborted;
    logic       word_write_timeout;
    logic       write_data_ready;
    logic       invalid_target_address;
    logic       access_locked;
    logic       busy;
    logic [3:0] write_buffer_valid;
    logic       pattern_fail;
  } fcsif_status_in_t;
endpackage : fcsif_pkg

// *** hdl/fcsif_flag_bit.sv ***
// one sticky event flag with set and clear sources
module fcsif_flag_bit (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // sources
  input  wire logic hw_set,
  input  wire logic sw_set,
  input  wire logic sw_clr,
  // state
  output logic      flag
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (sw_clr) begin
      flag_next = 1'b0;
    end
    // set beats clear so a coincident event is kept
    if (hw_set || sw_set) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule : fcsif_flag_bit

// *** dv/fcsif_top_asserts.sv ***
// checker: bus handshake, read map and interrupt relations at the top ports
module fcsif_top_asserts
  import fcsif_pkg::*;
(
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // register bus
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [7:0]    s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  // events and interrupt
  input wire fcsif_events_t events,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  // no event and no write offered, so nothing can raise the interrupt
  sequence s_quiet;
    !irq && events == '0 && !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h1C, 8'h30,
    8'h34, 8'h38, 8'h3C, 8'h40}) |=> s_axi_rresp == FCSIF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_stat_resv: assert property (s_rd(FCSIF_OFS_STATUS) |=> s_axi_rdata[23:7] == 17'h0)
    else $error("status reserved bits set");
  a_flag_resv: assert property (s_rd(FCSIF_OFS_FLAGS) |=> s_axi_rdata[31:9] == 23'h0 && !s_axi_rdata[7])
    else $error("flag reserved bits set");
  a_set_reads0: assert property (s_rd(FCSIF_OFS_FLAGS_SET) |=> s_axi_rdata == 32'h0)
    else $error("set register read not zero");
  a_irq_cause: assert property (s_quiet |=> !irq)
    else $error("interrupt rose without cause");
endmodule : fcsif_top_asserts

bind fcsif_top fcsif_top_asserts fcsif_top_asserts_i (.*);

// *** dv/fcsif_sw_model.sv ***
// partner: processor software as an axi4-lite master
module fcsif_sw_model (
  // clock
  input  wire logic  aclk,
  // write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  // read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // readies are sampled mid-cycle, when they have settled for the coming edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ra, rw, rb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {ra, rw, rb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
    end while (!rb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ra, rr;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ra, rr} = {s_axi_arready, s_axi_rvalid};
      @(posedge aclk);
      if (ra) s_axi_arvalid <= 1'b0;
    end while (!rr);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : fcsif_sw_model

// *** dv/fcsif_top_bench.sv ***
// testbench: flag, status and interrupt checks through the register bus
module fcsif_top_bench
  import fcsif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cnt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [8:0] fl, en, r;
  logic [34:0] q[$], exp;
  logic [1:0] bq[$], bexp;
  fcsif_events_t events;
  fcsif_status_in_t status_in;
  int err_total, checked, cyc, seed;
  fcsif_top fcsif_top_i (.*);
  fcsif_sw_model fcsif_sw_model_i (.*);
  always #4 aclk = ~aclk;
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // note the expected answer, then issue the read
  task automatic chk(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] d);
    q.push_back({|(fl & en), rs, d});
    fcsif_sw_model_i.rd(a);
  endtask : chk
  // note the expected write response, then issue the write
  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs, input logic [3:0] s);
    bq.push_back(rs);
    fcsif_sw_model_i.wr(a, d, s);
  endtask : put
  task automatic ev(input logic [7:0] e);
    @(posedge aclk) events <= e;
    @(posedge aclk) events <= '0;
    fl |= {e[7], 1'b0, e[6:0]};
  endtask : ev
  function automatic logic [31:0] stat();
    return {cnt, status_in[4:1], 17'h0, status_in[11:5]};
  endfunction : stat
  always @(negedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    exp = q.pop_front();
    checked++;
    if ({irq, s_axi_rresp, s_axi_rdata} !== exp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, {irq, s_axi_rresp, s_axi_rdata});
    end
  end
  always @(negedge aclk) if (s_axi_bvalid && s_axi_bready) begin
    bexp = bq.pop_front();
    checked++;
    if (s_axi_bresp !== bexp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, bexp, s_axi_bresp);
    end
  end
  always @(posedge aclk) if (++cyc == 20000) begin
    err_total++;
    end_of_test();
  end
  initial begin
    seed = 24341;
    events = '0;
    status_in = 12'($random(seed)) & 12'hFFE;
    {fl, en, cnt} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(FCSIF_OFS_STATUS, FCSIF_RESP_OKAY, stat());
    for (int k = 0; k < 2; k++) begin
      repeat (k ? 14 : 3) begin
        @(posedge aclk) status_in.pattern_fail <= 1'b1;
        @(posedge aclk) status_in.pattern_fail <= 1'b0;
        if (cnt != 4'hF) cnt++;
      end
      chk(FCSIF_OFS_STATUS, FCSIF_RESP_OKAY, stat());
    end
    put(FCSIF_OFS_STATUS, 32'hFFFFFFFF, FCSIF_RESP_OKAY, 4'hF);
    chk(FCSIF_OFS_STATUS, FCSIF_RESP_OKAY, stat());
    for (int i = 0; i < 8; i++) begin
      ev(8'(1 << i));
      chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'(fl));
    end
    chk(FCSIF_OFS_FLAGS_CLR, FCSIF_RESP_OKAY, 32'h0);
    for (int i = 0; i < 20; i++) begin
      en = 9'($random(seed)) & FCSIF_FLAG_MASK;
      put(FCSIF_OFS_ENABLE, 32'(en), FCSIF_RESP_OKAY, 4'hF);
      chk(FCSIF_OFS_ENABLE, FCSIF_RESP_OKAY, 32'(en));
      r = 9'($random(seed));
      put(FCSIF_OFS_FLAGS_SET, 32'(r), FCSIF_RESP_OKAY, 4'hF);
      fl |= r & FCSIF_FLAG_MASK;
      chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'(fl));
      r = 9'($random(seed));
      put(FCSIF_OFS_FLAGS_CLR, 32'(r), FCSIF_RESP_OKAY, 4'hF);
      fl &= ~r;
      chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'(fl));
      ev(8'($random(seed)));
      chk(FCSIF_OFS_FLAGS_SET, FCSIF_RESP_OKAY, 32'h0);
    end
    put(8'h44, 32'h1, FCSIF_RESP_SLVERR, 4'hF);
    chk(8'h44, FCSIF_RESP_SLVERR, 32'h0);
    put(FCSIF_OFS_FLAGS, 32'h1FF, FCSIF_RESP_OKAY, 4'hF);
    chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'(fl));
    // lane 1 alone carries bit 8, lane 0 carries bits 7:0
    put(FCSIF_OFS_ENABLE, 32'h0FF, FCSIF_RESP_OKAY, 4'h2);
    en &= 9'h0FF;
    chk(FCSIF_OFS_ENABLE, FCSIF_RESP_OKAY, 32'(en));
    put(FCSIF_OFS_ENABLE, 32'h1FF, FCSIF_RESP_OKAY, 4'h1);
    en = (en | 9'h0FF) & FCSIF_FLAG_MASK;
    chk(FCSIF_OFS_ENABLE, FCSIF_RESP_OKAY, 32'(en));
    // event and clear land on the same edge: the event must survive
    fl = '0;
    fork
      put(FCSIF_OFS_FLAGS_CLR, 32'h1FF, FCSIF_RESP_OKAY, 4'hF);
      ev(8'($random(seed)) | 8'h01);
    join
    chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'(fl));
    // read-clear returns the flags and empties them in one access
    put(FCSIF_OFS_OPTIONS, 32'h1, FCSIF_RESP_OKAY, 4'hF);
    chk(FCSIF_OFS_OPTIONS, FCSIF_RESP_OKAY, 32'h1);
    // flags are already clear when the answer stands, so irq is low then
    r = fl;
    fl = '0;
    chk(FCSIF_OFS_FLAGS_CLR, FCSIF_RESP_OKAY, 32'(r));
    chk(FCSIF_OFS_FLAGS, FCSIF_RESP_OKAY, 32'h0);
    repeat (3) @(posedge aclk);
    end_of_test();
  end
endmodule : fcsif_top_bench
